/* hdl/madc_pkg.sv */
/*
 * Shared constants and types of the multiplexed converter serial port.
 * Assumes a 20 MHz system clock and 32-bit AXI4-Lite register access.
 */
package madc_pkg;
    // ------------------------------------------------------------
    // Frame geometry
    // ------------------------------------------------------------
    localparam int unsigned MADC_RES_W = 12;
    localparam int unsigned MADC_FRAME_CLKS = 16;
    localparam int unsigned MADC_HIZ_CLKS = 4;
    localparam int unsigned MADC_SEL_CLKS = 2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned MADC_CLK_HZ = 20000000;
    localparam int unsigned MADC_SETTLE_US = 20;
    localparam int unsigned MADC_SETTLE_CYC = (MADC_SETTLE_US * (MADC_CLK_HZ / 1000000)
                                               + 0);
    localparam int unsigned MADC_CONV_NS = 3750;
    localparam int unsigned MADC_SCLK_MIN_NS = 250;
    localparam int unsigned MADC_CONV_CLKS = MADC_CONV_NS / MADC_SCLK_MIN_NS;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] MADC_CTRL_OFS = 4'h0;
    localparam logic [3:0] MADC_STAT_OFS = 4'h4;
    localparam logic [3:0] MADC_RSLT_OFS = 4'h8;
    localparam logic [31:0] MADC_CTRL_RST = 32'h0000_0000;
    localparam int unsigned MADC_CTRL_SHDN_BIT = 0;
    localparam int unsigned MADC_STAT_CHAN_LSB = 0;
    localparam int unsigned MADC_STAT_BUSY_BIT = 2;
    localparam int unsigned MADC_STAT_SETTLED_BIT = 3;
    localparam int unsigned MADC_STAT_PD_BIT = 4;
    localparam int unsigned MADC_STAT_EARLY_BIT = 5;
    localparam logic [1:0] MADC_RESP_OKAY = 2'h0;
    localparam logic [1:0] MADC_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MADC_IDLE = 3'h1,
        MADC_ACTIVE = 3'h2,
        MADC_DONE = 3'h4
    } madc_state_t;
endpackage

/* hdl/madc_axil_regs.sv */
/*
 * AXI4-Lite slave holding the control word and showing status and result.
 * Assumes one outstanding write and one outstanding read from the master.
 */
`timescale 1ns/1ps
module madc_axil_regs (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset
    input wire logic ce, // Clock enable
    input wire logic [3:0] s_axil_awaddr, // Write address
    input wire logic [2:0] s_axil_awprot, // Unused protection
    input wire logic s_axil_awvalid, // Write address valid
    output logic s_axil_awready, // Write address ready
    input wire logic [31:0] s_axil_wdata, // Write data
    input wire logic [3:0] s_axil_wstrb, // Byte strobes
    input wire logic s_axil_wvalid, // Write data valid
    output logic s_axil_wready, // Write data ready
    output logic [1:0] s_axil_bresp, // Write response
    output logic s_axil_bvalid, // Write response valid
    input wire logic s_axil_bready, // Write response ready
    input wire logic [3:0] s_axil_araddr, // Read address
    input wire logic [2:0] s_axil_arprot, // Unused protection
    input wire logic s_axil_arvalid, // Read address valid
    output logic s_axil_arready, // Read address ready
    output logic [31:0] s_axil_rdata, // Read data
    output logic [1:0] s_axil_rresp, // Read response
    output logic s_axil_rvalid, // Read data valid
    input wire logic s_axil_rready, // Read data ready
    output logic [31:0] ctrl_q, // Control word
    input wire logic [31:0] status_i, // Live status word
    input wire logic [31:0] result_i // Last sample
);
    import madc_pkg::*;

    logic aw_ok_q, w_ok_q, bvalid_q, rvalid_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;

    function automatic logic known(input logic [3:0] a);
        return (a == MADC_CTRL_OFS) || (a == MADC_STAT_OFS) || (a == MADC_RSLT_OFS);
    endfunction

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    // Readies follow ce: a frozen slave must not take a beat it cannot store
    assign s_axil_awready = ce & ~aw_ok_q & ~bvalid_q;
    assign s_axil_wready = ce & ~w_ok_q & ~bvalid_q;
    wire aw_hs = s_axil_awvalid & s_axil_awready;
    wire w_hs = s_axil_wvalid & s_axil_wready;
    wire [3:0] wr_addr = aw_ok_q ? awaddr_q : s_axil_awaddr;
    wire [31:0] wr_data = w_ok_q ? wdata_q : s_axil_wdata;
    wire [3:0] wr_strb = w_ok_q ? wstrb_q : s_axil_wstrb;
    wire do_wr = (aw_ok_q | aw_hs) & (w_ok_q | w_hs) & ~bvalid_q;
    wire ctrl_wr = do_wr && (wr_addr == MADC_CTRL_OFS) && wr_strb[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok_q <= 1'b0;
            w_ok_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= MADC_RESP_OKAY;
            ctrl_q <= MADC_CTRL_RST;
        end else if (ce) begin
            if (aw_hs) awaddr_q <= s_axil_awaddr;
            if (w_hs) begin
                wdata_q <= s_axil_wdata;
                wstrb_q <= s_axil_wstrb;
            end
            aw_ok_q <= do_wr ? 1'b0 : (aw_ok_q | aw_hs);
            w_ok_q <= do_wr ? 1'b0 : (w_ok_q | w_hs);
            if (do_wr) begin
                bvalid_q <= 1'b1;
                bresp_q <= known(wr_addr) ? MADC_RESP_OKAY : MADC_RESP_SLVERR;
            end else if (s_axil_bready) begin
                bvalid_q <= 1'b0;
            end
            // Only the low byte holds control bits
            if (ctrl_wr) ctrl_q <= {24'h0, wr_data[7:0]};
        end
    end
    assign s_axil_bvalid = bvalid_q;
    assign s_axil_bresp = bresp_q;

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    assign s_axil_arready = ce & ~rvalid_q;
    wire ar_hs = s_axil_arvalid & s_axil_arready;
    wire [31:0] rd_mux = (s_axil_araddr == MADC_CTRL_OFS) ? ctrl_q :
                         (s_axil_araddr == MADC_STAT_OFS) ? status_i :
                         (s_axil_araddr == MADC_RSLT_OFS) ? result_i : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= MADC_RESP_OKAY;
        end else if (ce) begin
            if (ar_hs) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= known(s_axil_araddr) ? MADC_RESP_OKAY : MADC_RESP_SLVERR;
            end else if (s_axil_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end
    assign s_axil_rvalid = rvalid_q;
    assign s_axil_rdata = rdata_q;
    assign s_axil_rresp = rresp_q;
endmodule

/* hdl/madc_serial_port.sv */
/*
 * Digital side of a 12-bit sampling converter with a two- or four-input
 * mux: select, serial clock, channel-select input, result output, shutdown.
 * Assumes every pin input is synchronous to aclk, which runs well above
 * the serial clock; analog inputs arrive here as 12-bit codes.
 */
`timescale 1ns/1ps
// What this block does
// - Shutdown low keeps converting; shutdown high forces idle low-power state.
// - After shutdown release, 20 us settling is tracked; earlier samples are flagged.
// - Select high leaves device idle; select low lets it follow serial clock.
// - Each result leaves the output as a twelve-bit serial word.
// - Results are unsigned straight binary, zero to all ones.
// - Conversion finishes inside fifteen serial clock periods of the frame.
// - Exactly one analog input, chosen by channel-select bits, is sampled.
// - Channel bits from frame n take effect for frame n+1 only.
// - Output high-impedance four clocks, then 12 bits MSB first on falls.
// - Select high clears logic, returns to sampling, releases the output.
module madc_serial_port #(
    parameter int unsigned NUM_CH = 4 // Mux inputs, 2 or 4
) (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset
    input wire logic ce, // Clock enable
    input wire logic [3:0] s_axil_awaddr, // Write address
    input wire logic [2:0] s_axil_awprot, // Unused protection
    input wire logic s_axil_awvalid, // Write address valid
    output logic s_axil_awready, // Write address ready
    input wire logic [31:0] s_axil_wdata, // Write data
    input wire logic [3:0] s_axil_wstrb, // Byte strobes
    input wire logic s_axil_wvalid, // Write data valid
    output logic s_axil_wready, // Write data ready
    output logic [1:0] s_axil_bresp, // Write response
    output logic s_axil_bvalid, // Write response valid
    input wire logic s_axil_bready, // Write response ready
    input wire logic [3:0] s_axil_araddr, // Read address
    input wire logic [2:0] s_axil_arprot, // Unused protection
    input wire logic s_axil_arvalid, // Read address valid
    output logic s_axil_arready, // Read address ready
    output logic [31:0] s_axil_rdata, // Read data
    output logic [1:0] s_axil_rresp, // Read response
    output logic s_axil_rvalid, // Read data valid
    input wire logic s_axil_rready, // Read data ready
    input wire logic dev_sel_n, // Device select, low selects
    input wire logic sclk, // Serial clock from host
    input wire logic chan_sel_din, // Channel-select data in
    input wire logic power_down_in, // High shuts down
    output logic dout_o, // Result data out
    output logic dout_oe, // Result output enable
    input wire logic [madc_pkg::MADC_RES_W-1:0] analog_in_0, // Input 0 code
    input wire logic [madc_pkg::MADC_RES_W-1:0] analog_in_1, // Input 1 code
    input wire logic [madc_pkg::MADC_RES_W-1:0] analog_in_2, // Input 2 code
    input wire logic [madc_pkg::MADC_RES_W-1:0] analog_in_3 // Input 3 code
);
    import madc_pkg::*;

    if (NUM_CH != 2 && NUM_CH != 4) begin : g_bad_num_ch
        $error("NUM_CH must be 2 or 4");
    end

    // ------------------------------------------------------------
    // Registers and decode
    // ------------------------------------------------------------
    madc_state_t state_q;
    logic sclk_q;
    logic [4:0] cnt_q;
    logic [1:0] chan_q;
    logic chan_sel_bit1_q, chan_sel_bit0_q;
    logic [MADC_RES_W-1:0] result_q;
    logic dout_q, oe_q, early_q;
    logic [8:0] settle_q;
    logic [31:0] ctrl_q;

    wire pd_eff = power_down_in | ctrl_q[MADC_CTRL_SHDN_BIT];
    wire abort = dev_sel_n | pd_eff;
    wire rise = sclk & ~sclk_q;
    wire fall = ~sclk & sclk_q;
    wire settled = (settle_q == 9'(MADC_SETTLE_CYC));
    wire frame_end = (state_q == MADC_ACTIVE) && rise && (cnt_q == 5'(MADC_FRAME_CLKS - 1));
    wire shift_bit = (state_q == MADC_ACTIVE) && fall && (cnt_q >= 5'(MADC_HIZ_CLKS))
                     && (cnt_q < 5'(MADC_FRAME_CLKS));
    // A dead clock after the sixteenth restarts a free-running frame
    wire start = !abort && ((state_q == MADC_IDLE) || ((state_q == MADC_DONE) && rise));
    wire [1:0] next_chan = (NUM_CH == 4) ? {chan_sel_bit1_q, chan_sel_bit0_q}
                                         : {1'b0, chan_sel_bit0_q};

    function automatic logic [MADC_RES_W-1:0] pick(input logic [1:0] c,
            input logic [MADC_RES_W-1:0] a0, input logic [MADC_RES_W-1:0] a1,
            input logic [MADC_RES_W-1:0] a2, input logic [MADC_RES_W-1:0] a3);
        return (c == 2'h0) ? a0 : (c == 2'h1) ? a1 : (c == 2'h2) ? a2 : a3;
    endfunction

    wire [MADC_RES_W-1:0] sel_sample = pick(chan_q, analog_in_0, analog_in_1,
                                            analog_in_2, analog_in_3);
    wire [3:0] bit_idx = 4'(4'(MADC_FRAME_CLKS - 1) - cnt_q[3:0]);

    // ------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= MADC_IDLE;
            sclk_q <= 1'b0;
            cnt_q <= 5'h00;
            result_q <= 12'h000;
            early_q <= 1'b0;
        end else if (ce) begin
            sclk_q <= sclk;
            if (abort) begin
                state_q <= MADC_IDLE;
                cnt_q <= 5'h00;
            end else if (start) begin
                state_q <= MADC_ACTIVE;
                cnt_q <= 5'h00;
                result_q <= sel_sample;
                early_q <= !settled;
            end else if (state_q == MADC_ACTIVE && rise) begin
                cnt_q <= 5'(cnt_q + 5'h01);
                if (frame_end) state_q <= MADC_DONE;
            end
        end
    end

    // capture now, apply at frame end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_q <= 2'h0;
            chan_sel_bit1_q <= 1'b0;
            chan_sel_bit0_q <= 1'b0;
        end else if (ce) begin
            if (!abort && state_q == MADC_ACTIVE && rise && cnt_q < 5'(MADC_SEL_CLKS)) begin
                chan_sel_bit1_q <= chan_sel_bit0_q;
                chan_sel_bit0_q <= chan_sel_din;
            end
            if (!abort && frame_end) chan_q <= next_chan;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dout_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (ce) begin
            if (abort) begin
                oe_q <= 1'b0;
            end else if (shift_bit) begin
                oe_q <= 1'b1;
                dout_q <= result_q[bit_idx];
            end else if (state_q != MADC_ACTIVE && fall) begin
                oe_q <= 1'b0;
            end else if (start) begin
                oe_q <= 1'b0;
            end
        end
    end
    assign dout_oe = oe_q & ~abort;
    assign dout_o = dout_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle_q <= 9'h000;
        end else if (ce) begin
            if (pd_eff) settle_q <= 9'h000;
            else if (!settled) settle_q <= 9'(settle_q + 9'h001);
        end
    end

    // ------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------
    wire [31:0] status_w = 32'(chan_q) << MADC_STAT_CHAN_LSB
                         | 32'(state_q != MADC_IDLE) << MADC_STAT_BUSY_BIT
                         | 32'(settled) << MADC_STAT_SETTLED_BIT
                         | 32'(pd_eff) << MADC_STAT_PD_BIT
                         | 32'(early_q) << MADC_STAT_EARLY_BIT;

    madc_axil_regs u_regs (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .s_axil_awaddr(s_axil_awaddr),
        .s_axil_awprot(s_axil_awprot),
        .s_axil_awvalid(s_axil_awvalid),
        .s_axil_awready(s_axil_awready),
        .s_axil_wdata(s_axil_wdata),
        .s_axil_wstrb(s_axil_wstrb),
        .s_axil_wvalid(s_axil_wvalid),
        .s_axil_wready(s_axil_wready),
        .s_axil_bresp(s_axil_bresp),
        .s_axil_bvalid(s_axil_bvalid),
        .s_axil_bready(s_axil_bready),
        .s_axil_araddr(s_axil_araddr),
        .s_axil_arprot(s_axil_arprot),
        .s_axil_arvalid(s_axil_arvalid),
        .s_axil_arready(s_axil_arready),
        .s_axil_rdata(s_axil_rdata),
        .s_axil_rresp(s_axil_rresp),
        .s_axil_rvalid(s_axil_rvalid),
        .s_axil_rready(s_axil_rready),
        .ctrl_q(ctrl_q),
        .status_i(status_w),
        .result_i({20'h00000, result_q})
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_start;
        ce && start;
    endsequence
    sequence s_last_rise;
        ce && !abort && frame_end;
    endsequence

    AST_PD_IDLE: assert property (ce && pd_eff |=> state_q == MADC_IDLE)
        else $error("shutdown did not idle the frame");
    AST_SETTLE_WAIT: assert property (ce && $fell(pd_eff) |-> !settled)
        else $error("settled without waiting");
    AST_DESEL_IDLE: assert property (ce && dev_sel_n |=> state_q == MADC_IDLE && !dout_oe)
        else $error("deselect did not idle");
    AST_BIT_ORDER: assert property (ce && !abort && shift_bit
        |=> dout_q == $past(result_q[bit_idx]))
        else $error("wrong result bit driven");
    AST_ZERO_CODE: assert property (oe_q && result_q == 12'h000 |-> !dout_q)
        else $error("zero code drove a one");
    AST_FRAME_START: assert property (s_start
        |=> state_q == MADC_ACTIVE && cnt_q == 5'h00)
        else $error("frame did not start");
    AST_SAMPLE_SEL: assert property (s_start |=> result_q == $past(sel_sample))
        else $error("sample not from selected input");
    AST_CHAN_NEXT: assert property (s_last_rise |=> chan_q == $past(next_chan))
        else $error("channel not applied at frame end");
    AST_CHAN_HOLD: assert property (ce && !frame_end |=> $stable(chan_q))
        else $error("channel changed mid frame");
    AST_HIZ_FIRST: assert property (state_q == MADC_ACTIVE && cnt_q < 5'(MADC_HIZ_CLKS)
        |-> !oe_q)
        else $error("output driven in first four clocks");
    AST_DESEL_HIZ: assert property (dev_sel_n |-> !dout_oe)
        else $error("output driven while deselected");
    AST_INDEX: assert property (chan_q == 2'h1 |-> sel_sample == analog_in_1)
        else $error("code one not routed to input one");
endmodule

/* sim/madc_host_model.sv */
/*
 * Host-side model of the converter serial pins: select, clock, channel bits.
 * Assumes aclk at 20 MHz; each serial clock phase lasts whole aclk cycles.
 */
`timescale 1ns/1ps
module madc_host_model (
    input wire logic aclk, // System clock
    input wire logic dout_o, // Result bit
    input wire logic dout_oe, // Result enable
    output logic dev_sel_n, // Device select, low selects
    output logic sclk, // Serial clock
    output logic chan_sel_din, // Channel-select bits
    output logic [13:0] frame_o, // Driven seen, pattern ok, word
    output logic frame_vld // One-cycle frame report
);
    // ------------------------------------------------------------
    // Frame driver
    // ------------------------------------------------------------
    initial begin
        dev_sel_n = 1'b1;
        sclk = 1'b0;
        chan_sel_din = 1'b0;
        frame_o = 14'h0;
        frame_vld = 1'b0;
    end

    // Select, shift MSB first, sample on rises
    task automatic run_frame(input logic [1:0] code, input int abort_at, input int half);
        logic [11:0] w;
        logic ok;
        logic any;
        w = 12'h0;
        ok = 1'b1;
        any = 1'b0;
        @(posedge aclk);
        dev_sel_n <= 1'b0;
        repeat (3) @(posedge aclk);
        for (int k = 1; k <= 16; k++) begin
            sclk <= 1'b0;
            // Unused slots toggle so a stale level is never mistaken
            chan_sel_din <= (k == 1) ? code[1] : (k == 2) ? code[0] : ~chan_sel_din;
            repeat (half) @(posedge aclk);
            if (k == abort_at) begin
                dev_sel_n <= 1'b1;
                return;
            end
            sclk <= 1'b1;
            if (dout_oe === 1'b1) any = 1'b1;
            if (k > 4 && dout_oe === 1'b1) w[16 - k] = dout_o;
            ok = ok & (dout_oe === (k > 4));
            repeat (half) @(posedge aclk);
        end
        sclk <= 1'b0;
        repeat (half) @(posedge aclk);
        ok = ok & (dout_oe === 1'b0);
        dev_sel_n <= 1'b1;
        frame_o <= {any, ok, w};
        frame_vld <= 1'b1;
        @(posedge aclk);
        frame_vld <= 1'b0;
    endtask
endmodule

/* sim/tb_top.sv */
/*
 * Self-checking bench: register slave over AXI4-Lite plus the serial pins.
 * Assumes the host model is the only serial master and one bus master here.
 */
`timescale 1ns/1ps
module tb_top;
    import madc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, power_down_in = 1'b0;
    logic [2:0] s_axil_awprot = 3'h0, s_axil_arprot = 3'h0;
    logic [3:0] s_axil_awaddr = 4'h0, s_axil_araddr = 4'h0, s_axil_wstrb = 4'h0;
    logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
    logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
    logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
    logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    logic [1:0] s_axil_bresp, s_axil_rresp;
    logic dev_sel_n, sclk, chan_sel_din, dout_o, dout_oe, frame_vld;
    logic [13:0] frame_o;
    logic [11:0] ain [4] = '{default: 12'h0};
    logic [13:0] fr_q [$];
    logic [1:0] b_q [$];
    logic [33:0] r_q [$], m_q [$];
    logic [33:0] msk;
    logic [1:0] cur_ch = 2'h0;
    logic [1:0] codes [6] = '{2'h2, 2'h3, 2'h1, 2'h0, 2'h3, 2'h2};
    int error_cnt = 0, cmp_count = 0, seed;

    always #25 aclk = ~aclk;

    madc_serial_port #(.NUM_CH(4)) madc_serial_port_inst (
        .aclk, .aresetn, .ce, .s_axil_awaddr, .s_axil_awprot, .s_axil_awvalid,
        .s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready,
        .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arprot,
        .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid,
        .s_axil_rready, .dev_sel_n, .sclk, .chan_sel_din, .power_down_in, .dout_o,
        .dout_oe, .analog_in_0(ain[0]), .analog_in_1(ain[1]), .analog_in_2(ain[2]),
        .analog_in_3(ain[3])
    );
    madc_host_model madc_host_model_inst (
        .aclk, .dout_o, .dout_oe, .dev_sel_n, .sclk, .chan_sel_din, .frame_o, .frame_vld
    );

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic to_fail();
        error_cnt++;
        end_of_test();
    endtask

    // Oldest note is compared whenever a result shows up
    always @(posedge aclk) begin
        if (frame_vld) begin
            check({20'h0, frame_o}, {20'h0, fr_q.pop_front()});
        end
        if (s_axil_bvalid && s_axil_bready) begin
            check(34'(s_axil_bresp), 34'(b_q.pop_front()));
        end
        if (s_axil_rvalid && s_axil_rready) begin
            msk = m_q.pop_front();
            check({s_axil_rresp, s_axil_rdata} & msk, r_q.pop_front());
        end
    end

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st,
                       input logic [1:0] resp);
        int n;
        b_q.push_back(resp);
        @(posedge aclk);
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_wstrb <= st;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        s_axil_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axil_awvalid && s_axil_awready) s_axil_awvalid <= 1'b0;
            if (s_axil_wvalid && s_axil_wready) s_axil_wvalid <= 1'b0;
            if (s_axil_bvalid) break;
        end
        s_axil_bready <= 1'b0;
        if (n >= 100) to_fail();
    endtask

    task automatic axr(input logic [3:0] a, input logic [33:0] exp, input logic [33:0] m);
        int n;
        r_q.push_back(exp & m);
        m_q.push_back(m);
        @(posedge aclk);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'b1;
        s_axil_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axil_arvalid && s_axil_arready) s_axil_arvalid <= 1'b0;
            if (s_axil_rvalid) break;
        end
        s_axil_rready <= 1'b0;
        if (n >= 100) to_fail();
    endtask

    // Zero and full scale first, random codes after
    task automatic new_ain(input int i);
        @(posedge aclk);
        for (int j = 0; j < 4; j++) begin
            ain[j] <= (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($urandom);
        end
        @(posedge aclk);
    endtask

    task automatic frame(input logic [1:0] code, input logic [13:0] exp, input int abort_at);
        if (abort_at == 0) fr_q.push_back(exp);
        madc_host_model_inst.run_frame(code, abort_at, 3 + int'($urandom % 3));
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = $urandom(72);
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axw(MADC_CTRL_OFS, 32'h1, 4'hf, MADC_RESP_OKAY);
        axr(MADC_STAT_OFS, 34'h10, 34'h3_0000_0014);
        axw(MADC_CTRL_OFS, 32'h0, 4'h0, MADC_RESP_OKAY);
        axr(MADC_CTRL_OFS, 34'h1, 34'h3_ffff_ffff);
        axw(4'hc, 32'h1, 4'hf, MADC_RESP_SLVERR);
        axr(4'hc, {MADC_RESP_SLVERR, 32'h0}, 34'h3_ffff_ffff);
        axw(MADC_CTRL_OFS, 32'h0, 4'hf, MADC_RESP_OKAY);
        @(posedge aclk);
        power_down_in <= 1'b1;
        frame(2'h3, 14'h0, 0);
        axr(MADC_STAT_OFS, 34'h10, 34'h3_0000_0014);
        @(posedge aclk);
        power_down_in <= 1'b0;
        axr(MADC_STAT_OFS, 34'h0, 34'h3_0000_0018);
        new_ain(2);
        frame(2'h1, {2'b11, ain[cur_ch]}, 0);
        cur_ch = 2'h1;
        axr(MADC_STAT_OFS, 34'h21, 34'h3_0000_002b);
        repeat (420) @(posedge aclk);
        axr(MADC_STAT_OFS, 34'h8, 34'h3_0000_0008);
        // Frozen slave must hold off the read, not lose it
        ce <= 1'b0;
        fork
            axr(MADC_STAT_OFS, 34'h29, 34'h3_0000_003f);
            begin
                repeat (6) @(posedge aclk);
                ce <= 1'b1;
            end
        join
        for (int i = 0; i < 6; i++) begin
            new_ain(i);
            frame(codes[i], {2'b11, ain[cur_ch]}, 0);
            cur_ch = codes[i];
            axr(MADC_STAT_OFS, 34'h8 | 34'(cur_ch), 34'h3_0000_003f);
        end
        new_ain(3);
        frame(2'h1, 14'h0, 7);
        @(posedge aclk);
        #1;
        check(34'(dout_oe), 34'h0);
        new_ain(4);
        frame(2'h0, {2'b11, ain[cur_ch]}, 0);
        cur_ch = 2'h0;
        axr(MADC_STAT_OFS, 34'h8, 34'h3_0000_003f);
        repeat (4) @(posedge aclk);
        end_of_test();
    end
endmodule
